// ==== src/mrd_reference_regs.sv ====
// reference-data register bank with byte-serial master access
`timescale 1ns/10ps
module mrd_reference_regs (
    input wire logic mclk,
    input wire logic rstn,
    input wire mrd_pkg::mrd_access_t access,
    input wire logic wr_byte_valid,
    input wire logic [mrd_pkg::BYTE_W-1:0] wr_byte,
    input wire logic rd_byte_req,
    input wire logic drive_fault_contact,
    input wire logic [mrd_pkg::BCAST_CNT-1:0] bcast_terminal,
    output logic rd_byte_valid,
    output logic [mrd_pkg::BYTE_W-1:0] rd_byte,
    output mrd_pkg::mrd_command_t command,
    output logic [mrd_pkg::DATA_W-1:0] frequency_reference,
    output logic [mrd_pkg::DATA_W-1:0] pi_target,
    output logic pi_target_valid,
    output logic signed [mrd_pkg::DATA_W-1:0] analog_out_one,
    output logic signed [mrd_pkg::DATA_W-1:0] analog_out_two,
    output mrd_pkg::mrd_terminal_t terminals
);
    // ------------------------------------------------------------
    // access pointer and byte pairing
    // ------------------------------------------------------------
    logic [mrd_pkg::ADDR_W-1:0] ptr_r, ptr_nxt;
    logic lo_phase_r, lo_phase_nxt;
    logic [mrd_pkg::BYTE_W-1:0] hi_r, hi_nxt;
    logic [mrd_pkg::BYTE_W-1:0] rd_lo_r, rd_lo_nxt;
    logic rd_byte_valid_r, rd_byte_valid_nxt;
    logic [mrd_pkg::BYTE_W-1:0] rd_byte_r, rd_byte_nxt;
    logic commit;
    logic [mrd_pkg::DATA_W-1:0] commit_word;
    logic [mrd_pkg::IDX_W-1:0] ptr_idx;
    logic in_map;
    logic [mrd_pkg::DATA_W-1:0] regs_r [mrd_pkg::REG_CNT];
    logic [mrd_pkg::DATA_W-1:0] regs_nxt [mrd_pkg::REG_CNT];
    logic [mrd_pkg::DATA_W-1:0] rd_word;

    assign ptr_idx = ptr_r[mrd_pkg::IDX_W-1:0];
    assign in_map = (ptr_r < 16'(mrd_pkg::REG_CNT));
    assign rd_word = in_map ? regs_r[ptr_idx] : mrd_pkg::RESET_WORD;

    always_comb begin
        ptr_nxt = ptr_r;
        lo_phase_nxt = lo_phase_r;
        hi_nxt = hi_r;
        rd_lo_nxt = rd_lo_r;
        rd_byte_valid_nxt = 1'b0;
        rd_byte_nxt = rd_byte_r;
        commit = 1'b0;
        commit_word = {hi_r, wr_byte};
        if (access.start) begin
            ptr_nxt = access.addr;
            lo_phase_nxt = 1'b0;
        end else if (wr_byte_valid) begin
            if (!lo_phase_r) begin
                hi_nxt = wr_byte;
                lo_phase_nxt = 1'b1;
            end else begin
                commit = 1'b1;
                lo_phase_nxt = 1'b0;
                ptr_nxt = ptr_r + 16'h0001;
            end
        end else if (rd_byte_req) begin
            rd_byte_valid_nxt = 1'b1;
            if (!lo_phase_r) begin
                rd_byte_nxt = rd_word[mrd_pkg::DATA_W-1:mrd_pkg::BYTE_W];
                rd_lo_nxt = rd_word[mrd_pkg::BYTE_W-1:0];
                lo_phase_nxt = 1'b1;
            end else begin
                rd_byte_nxt = rd_lo_r;
                lo_phase_nxt = 1'b0;
                ptr_nxt = ptr_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr_r <= 16'h0000;
            lo_phase_r <= 1'b0;
            hi_r <= 8'h00;
            rd_lo_r <= 8'h00;
            rd_byte_valid_r <= 1'b0;
            rd_byte_r <= 8'h00;
        end else begin
            ptr_r <= ptr_nxt;
            lo_phase_r <= lo_phase_nxt;
            hi_r <= hi_nxt;
            rd_lo_r <= rd_lo_nxt;
            rd_byte_valid_r <= rd_byte_valid_nxt;
            rd_byte_r <= rd_byte_nxt;
        end
    end

    assign rd_byte_valid = rd_byte_valid_r;
    assign rd_byte = rd_byte_r;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // unimplemented bits stored as zero, reserved word never written
    genvar gi;
    generate
        for (gi = 0; gi < mrd_pkg::REG_CNT; gi++) begin : g_reg
            localparam int IW = mrd_pkg::IDX_W;
            localparam logic [mrd_pkg::IDX_W-1:0] IDX = IW'(gi);
            always_comb begin
                regs_nxt[gi] = regs_r[gi];
                if (commit && in_map && ptr_idx == IDX && IDX != mrd_pkg::IDX_RESERVED) begin
                    regs_nxt[gi] = commit_word & mrd_pkg::reg_mask(IDX);
                end
            end
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    regs_r[gi] <= mrd_pkg::RESET_WORD;
                end else begin
                    regs_r[gi] <= regs_nxt[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // drive-facing outputs
    // ------------------------------------------------------------
    mrd_pkg::mrd_command_t command_r, command_nxt;
    mrd_pkg::mrd_terminal_t terminals_r, terminals_nxt;
    logic [mrd_pkg::DATA_W-1:0] freq_r, freq_nxt;
    logic [mrd_pkg::DATA_W-1:0] pi_r, pi_nxt;
    logic pi_valid_r, pi_valid_nxt;
    logic signed [mrd_pkg::DATA_W-1:0] ao_one_r, ao_one_nxt;
    logic signed [mrd_pkg::DATA_W-1:0] ao_two_r, ao_two_nxt;
    logic [mrd_pkg::DATA_W-1:0] op_w, co_w, rs_w;
    logic fault_reset_hit;

    function automatic logic signed [mrd_pkg::DATA_W-1:0] ao_clamp(input logic signed [mrd_pkg::DATA_W-1:0] v);
        logic signed [mrd_pkg::DATA_W-1:0] r;
        r = v;
        if (v > mrd_pkg::AO_MAX) begin
            r = mrd_pkg::AO_MAX;
        end else if (v < mrd_pkg::AO_MIN) begin
            r = mrd_pkg::AO_MIN;
        end
        return r;
    endfunction

    assign op_w = regs_r[mrd_pkg::IDX_OP_CMD];
    assign co_w = regs_r[mrd_pkg::IDX_CONTACT_OUT];
    assign rs_w = regs_r[mrd_pkg::IDX_REF_SELECT];
    // fault reset fires on every write of a one, even if already one
    assign fault_reset_hit = commit && in_map && ptr_idx == mrd_pkg::IDX_OP_CMD
        && commit_word[mrd_pkg::OP_FAULT_RESET];

    always_comb begin
        command_nxt.run_forward = op_w[mrd_pkg::OP_RUN_FWD];
        command_nxt.run_reverse = op_w[mrd_pkg::OP_RUN_REV];
        command_nxt.external_fault_flag = op_w[mrd_pkg::OP_EXT_FAULT];
        command_nxt.fault_reset = fault_reset_hit;
        command_nxt.network_reference_select = op_w[mrd_pkg::OP_NET_REF];
        command_nxt.network_command_select = op_w[mrd_pkg::OP_NET_CMD];
        command_nxt.mf_input_cmd = op_w[mrd_pkg::OP_MF_LO +: mrd_pkg::MF_CNT];
        freq_nxt = regs_r[mrd_pkg::IDX_FREQ_REF];
        pi_valid_nxt = rs_w[mrd_pkg::RS_PI_ENABLE];
        pi_nxt = pi_valid_nxt ? regs_r[mrd_pkg::IDX_PI_SETPOINT] : mrd_pkg::RESET_WORD;
        ao_one_nxt = ao_clamp(regs_r[mrd_pkg::IDX_AO_ONE]);
        ao_two_nxt = ao_clamp(regs_r[mrd_pkg::IDX_AO_TWO]);
        terminals_nxt.digital_output_one_terminal = co_w[mrd_pkg::CO_DOUT_ONE];
        terminals_nxt.digital_output_two_terminal = co_w[mrd_pkg::CO_DOUT_TWO];
        terminals_nxt.fault_contact_terminal = co_w[mrd_pkg::CO_FAULT_OVR]
            ? co_w[mrd_pkg::CO_FAULT_VAL] : drive_fault_contact;
        terminals_nxt.input_terminal_five = bcast_terminal[0] & rs_w[mrd_pkg::RS_BCAST_LO];
        terminals_nxt.input_terminal_six = bcast_terminal[1] & rs_w[mrd_pkg::RS_BCAST_LO + 1];
        terminals_nxt.input_terminal_seven = bcast_terminal[2] & rs_w[mrd_pkg::RS_BCAST_LO + 2];
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            command_r <= '0;
            terminals_r <= '0;
            freq_r <= mrd_pkg::RESET_WORD;
            pi_r <= mrd_pkg::RESET_WORD;
            pi_valid_r <= 1'b0;
            ao_one_r <= mrd_pkg::RESET_WORD;
            ao_two_r <= mrd_pkg::RESET_WORD;
        end else begin
            command_r <= command_nxt;
            terminals_r <= terminals_nxt;
            freq_r <= freq_nxt;
            pi_r <= pi_nxt;
            pi_valid_r <= pi_valid_nxt;
            ao_one_r <= ao_one_nxt;
            ao_two_r <= ao_two_nxt;
        end
    end

    assign command = command_r;
    assign terminals = terminals_r;
    assign frequency_reference = freq_r;
    assign pi_target = pi_r;
    assign pi_target_valid = pi_valid_r;
    assign analog_out_one = ao_one_r;
    assign analog_out_two = ao_two_r;
endmodule

// ==== src/mrd_pkg.sv ====
// constants and types of the reference-data register bank
// Summary of operation
// - bit 0 runs forward, bit 1 reverse
// - command bit 2 raises external fault
// - command bit 3 written one resets faults
// - bits 6..A drive input commands 3..7
// - frequency reference held at 0002H
// - PI setpoint used only when enabled
// - analog output 1, 660 counts = 10 V
// - analog output 2, same scaling
// - contact bits 0,1 switch digital outputs
// - bit 7 drives fault contact if bit 6
// - broadcast terminals 5..7 gated by C..E
// - registers 1,2,6..9,F read and write, the others read zero
// - upper byte first, ascending register order
package mrd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 4;
    localparam int REG_CNT = 16;

    // register numbers
    localparam logic [IDX_W-1:0] IDX_RESERVED = 4'h0;
    localparam logic [IDX_W-1:0] IDX_OP_CMD = 4'h1;
    localparam logic [IDX_W-1:0] IDX_FREQ_REF = 4'h2;
    localparam logic [IDX_W-1:0] IDX_PI_SETPOINT = 4'h6;
    localparam logic [IDX_W-1:0] IDX_AO_ONE = 4'h7;
    localparam logic [IDX_W-1:0] IDX_AO_TWO = 4'h8;
    localparam logic [IDX_W-1:0] IDX_CONTACT_OUT = 4'h9;
    localparam logic [IDX_W-1:0] IDX_REF_SELECT = 4'hF;

    // implemented bits per register
    localparam logic [DATA_W-1:0] MASK_OP_CMD = 16'h07FF;
    localparam logic [DATA_W-1:0] MASK_FULL = 16'hFFFF;
    localparam logic [DATA_W-1:0] MASK_CONTACT_OUT = 16'h00C3;
    localparam logic [DATA_W-1:0] MASK_REF_SELECT = 16'h7002;
    localparam logic [DATA_W-1:0] MASK_NONE = 16'h0000;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

    // operation-command fields
    localparam int OP_RUN_FWD = 0;
    localparam int OP_RUN_REV = 1;
    localparam int OP_EXT_FAULT = 2;
    localparam int OP_FAULT_RESET = 3;
    localparam int OP_NET_REF = 4;
    localparam int OP_NET_CMD = 5;
    localparam int OP_MF_LO = 6;
    localparam int MF_CNT = 5;

    // contact-output fields
    localparam int CO_DOUT_ONE = 0;
    localparam int CO_DOUT_TWO = 1;
    localparam int CO_FAULT_OVR = 6;
    localparam int CO_FAULT_VAL = 7;

    // reference-selection fields
    localparam int RS_PI_ENABLE = 1;
    localparam int RS_BCAST_LO = 12;
    localparam int BCAST_CNT = 3;

    // analog scaling: counts per 10 V and the clamp at 11 V
    localparam int AO_COUNTS_10V = 660;
    localparam logic signed [DATA_W-1:0] AO_MAX = 16'sh02D6;
    localparam logic signed [DATA_W-1:0] AO_MIN = -16'sh02D6;

    function automatic logic [DATA_W-1:0] reg_mask(input logic [IDX_W-1:0] idx);
        logic [DATA_W-1:0] m;
        m = MASK_NONE;
        unique case (idx)
            IDX_OP_CMD: m = MASK_OP_CMD;
            IDX_FREQ_REF, IDX_PI_SETPOINT, IDX_AO_ONE, IDX_AO_TWO: m = MASK_FULL;
            IDX_CONTACT_OUT: m = MASK_CONTACT_OUT;
            IDX_REF_SELECT: m = MASK_REF_SELECT;
            default: m = MASK_NONE;
        endcase
        return m;
    endfunction

    typedef struct packed {
        logic start;
        logic write;
        logic [ADDR_W-1:0] addr;
    } mrd_access_t;

    typedef struct packed {
        logic run_forward;
        logic run_reverse;
        logic external_fault_flag;
        logic fault_reset;
        logic network_reference_select;
        logic network_command_select;
        logic [MF_CNT-1:0] mf_input_cmd;
    } mrd_command_t;

    typedef struct packed {
        logic digital_output_one_terminal;
        logic digital_output_two_terminal;
        logic fault_contact_terminal;
        logic input_terminal_five;
        logic input_terminal_six;
        logic input_terminal_seven;
    } mrd_terminal_t;
endpackage

// ==== verification/mrd_regs_properties.sv ====
// port assertions for the reference-data register bank
`timescale 1ns/10ps
module mrd_regs_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire mrd_pkg::mrd_access_t access,
    input wire logic wr_byte_valid,
    input wire logic rd_byte_req,
    input wire logic [2:0] bcast_terminal,
    input wire logic rd_byte_valid,
    input wire mrd_pkg::mrd_command_t command,
    input wire logic [15:0] pi_target,
    input wire logic pi_target_valid,
    input wire logic signed [15:0] analog_out_one,
    input wire logic signed [15:0] analog_out_two,
    input wire mrd_pkg::mrd_terminal_t terminals
);
    // ----------
    // checks
    // ----------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        !wr_byte_valid ##1 !wr_byte_valid;
    endsequence
    sequence s_rd_taken;
        rd_byte_req && !access.start && !wr_byte_valid;
    endsequence
    a_rd_answer: assert property (s_rd_taken |=> rd_byte_valid)
        else $error("read byte not answered");
    a_rd_spurious: assert property (!(rd_byte_req && !access.start && !wr_byte_valid) |=> !rd_byte_valid)
        else $error("read byte without request");
    a_pi_gate: assert property (!pi_target_valid |-> pi_target == 16'h0000)
        else $error("pi target while disabled");
    a_ao_one_range: assert property (analog_out_one <= mrd_pkg::AO_MAX && analog_out_one >= mrd_pkg::AO_MIN)
        else $error("analog one out of range");
    a_ao_two_range: assert property (analog_out_two <= mrd_pkg::AO_MAX && analog_out_two >= mrd_pkg::AO_MIN)
        else $error("analog two out of range");
    a_bcast_gate: assert property ((terminals[2:0] & ~{$past(bcast_terminal[0]), $past(bcast_terminal[1]),
        $past(bcast_terminal[2])}) == 3'h0)
        else $error("terminal set without broadcast input");
    a_reset_pulse: assert property (command.fault_reset |=> !command.fault_reset)
        else $error("fault reset longer than a cycle");
    a_cmd_hold: assert property (s_quiet |=> $stable(command[10:8]))
        else $error("run or fault bits moved without write");
    a_dout_hold: assert property (s_quiet |=> $stable(terminals[5:4]))
        else $error("digital outputs moved without write");
endmodule

bind mrd_reference_regs mrd_regs_checker chk (.mclk(mclk), .rstn(rstn), .access(access),
    .wr_byte_valid(wr_byte_valid), .rd_byte_req(rd_byte_req), .bcast_terminal(bcast_terminal),
    .rd_byte_valid(rd_byte_valid), .command(command), .pi_target(pi_target), .pi_target_valid(pi_target_valid),
    .analog_out_one(analog_out_one), .analog_out_two(analog_out_two), .terminals(terminals));

// ==== verification/mrd_master_model.sv ====
// master model driving the byte access port of the register bank
`timescale 1ns/10ps
module mrd_master_model (
    input wire logic mclk,
    input wire logic rd_byte_valid,
    input wire logic [7:0] rd_byte,
    output mrd_pkg::mrd_access_t access,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic rd_byte_req
);
    // ----------
    // transfers, entered at a falling edge
    // ----------
    initial begin
        access = 18'h00000;
        wr_byte_valid = 1'b0;
        wr_byte = 8'h5A;
        rd_byte_req = 1'b0;
    end
    task automatic open_at(input logic [15:0] a, input logic wr);
        access = {1'b1, wr, a};
        @(negedge mclk);
        access = {1'b0, wr, ~a};
    endtask
    task automatic write_burst(input logic [15:0] a, input logic [15:0] w[$]);
        if (a == 16'h0000) return;
        open_at(a, 1'b1);
        wr_byte_valid = 1'b1;
        foreach (w[i]) begin
            wr_byte = w[i][15:8];
            @(negedge mclk);
            wr_byte = w[i][7:0];
            @(negedge mclk);
        end
        wr_byte_valid = 1'b0;
        wr_byte = ~wr_byte;
    endtask
    task automatic read_burst(input logic [15:0] a, input int n, output logic [15:0] r[$], output logic ok);
        logic [7:0] hi;
        r = {};
        ok = 1'b1;
        open_at(a, 1'b0);
        rd_byte_req = 1'b1;
        for (int k = 1; k <= 2 * n; k++) begin
            @(negedge mclk);
            if (k == 2 * n) rd_byte_req = 1'b0;
            ok = ok && (rd_byte_valid === 1'b1);
            if (k % 2 == 1) hi = rd_byte;
            else r.push_back({hi, rd_byte});
        end
    endtask
endmodule

// ==== verification/test_modbus_reference_data_regs.sv ====
// self-checking bench of the reference-data register bank
`timescale 1ns/10ps
module test_modbus_reference_data_regs;
    typedef struct { logic [3:0] a; logic [15:0] w; logic [15:0] o; } mrd_row_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic drive_fault_contact = 1'b0;
    logic [2:0] bcast_terminal = 3'h1;
    mrd_pkg::mrd_access_t access;
    logic wr_byte_valid, rd_byte_req, rd_byte_valid, pi_target_valid, ok;
    logic [7:0] wr_byte, rd_byte;
    mrd_pkg::mrd_command_t command;
    mrd_pkg::mrd_terminal_t terminals;
    logic [15:0] frequency_reference, pi_target, n;
    logic signed [15:0] analog_out_one, analog_out_two;
    logic [15:0] rq[$], wq[$];
    int mismatches = 0;
    int n_compared = 0;
    mrd_row_t rows[15] = '{'{4'h1, 16'h0005, 16'h0500}, '{4'h1, 16'h07C0, 16'h001F}, '{4'h1, 16'h0270, 16'h0069},
        '{4'h2, 16'h1234, 16'h1234},
        '{4'hF, 16'h7002, 16'h0009}, '{4'h6, 16'hABCD, 16'hABCD}, '{4'hF, 16'h6000, 16'h0000},
        '{4'h6, 16'h1357, 16'h0000}, '{4'h7, 16'h0294, 16'h0294}, '{4'h7, 16'h0300, 16'h02D6},
        '{4'h8, 16'hFD2A, 16'hFD2A}, '{4'h8, 16'h8000, 16'hFD2A}, '{4'h9, 16'h0003, 16'h0006},
        '{4'h9, 16'h00C0, 16'h0001}, '{4'h9, 16'h0080, 16'h0000}};
    always #50 mclk = ~mclk;
    mrd_reference_regs dut (.mclk(mclk), .rstn(rstn), .access(access), .wr_byte_valid(wr_byte_valid),
        .wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .drive_fault_contact(drive_fault_contact),
        .bcast_terminal(bcast_terminal), .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte), .command(command),
        .frequency_reference(frequency_reference), .pi_target(pi_target), .pi_target_valid(pi_target_valid),
        .analog_out_one(analog_out_one), .analog_out_two(analog_out_two), .terminals(terminals));
    mrd_master_model m (.mclk(mclk), .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte), .access(access),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req));
    // ----------
    // helpers
    // ----------
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input int cnt);
        m.read_burst(a, cnt, rq, ok);
        n_compared++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED %0t read byte not answered", $time);
            final_report();
        end
    endtask
    function automatic logic [15:0] obs(input logic [3:0] a);
        case (a)
            4'h1: return {5'h00, command};
            4'h2: return frequency_reference;
            4'h6: return pi_target;
            4'h7: return analog_out_one;
            4'h8: return analog_out_two;
            4'h9: return {13'h0000, terminals[5:3]};
            default: return {12'h000, terminals[2:0], pi_target_valid};
        endcase
    endfunction
    // ----------
    // sequence
    // ----------
    initial begin
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        foreach (rows[i]) begin
            wq = '{rows[i].w};
            m.write_burst({12'h000, rows[i].a}, wq);
            rd({12'h000, rows[i].a}, 1);
            check_word(rq[0], rows[i].w, "readback");
            check_word(obs(rows[i].a), rows[i].o, "output");
        end
        $display("table test done");
        wq = '{16'h0101, 16'h0202, 16'h0303, 16'hFFFF};
        m.write_burst(16'h0006, wq);
        rd(16'h0005, 6);
        wq = '{16'h0000, 16'h0101, 16'h0202, 16'h0303, 16'h00C3, 16'h0000};
        foreach (wq[i]) check_word(rq[i], wq[i], "burst word");
        $display("burst test done");
        wq = '{16'h0008};
        m.write_burst(16'h0001, wq);
        n = 16'h0000;
        repeat (4) begin
            n = n + {15'h0000, command.fault_reset};
            @(negedge mclk);
        end
        check_word(n, 16'h0001, "fault reset pulses");
        $display("fault reset test done");
        bcast_terminal = 3'h7;
        wq = '{16'h2000};
        m.write_burst(16'h000F, wq);
        repeat (2) @(negedge mclk);
        check_word(obs(4'hF), 16'h0004, "broadcast gate");
        $display("broadcast test done");
        drive_fault_contact = 1'b1;
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        rd(16'h0000, 16);
        foreach (rq[i]) check_word(rq[i], 16'h0000, "reset word");
        check_word({15'h0000, terminals.fault_contact_terminal}, 16'h0001, "fault contact");
        $display("reset test done");
        final_report();
    end
endmodule
